// file: core/afcs_consts.svh
// Constants for the analog frequency command scaler.
`ifndef AFCS_CONSTS_SVH
`define AFCS_CONSTS_SVH
`define AFCS_FLD_SPAN      3'h0
`define AFCS_FLD_ZERO      3'h1
`define AFCS_FLD_SFREQ     3'h2
`define AFCS_FLD_EFREQ     3'h3
`define AFCS_FLD_SPT       3'h4
`define AFCS_FLD_EPT       3'h5
`define AFCS_FLD_SEL       3'h6
`define AFCS_OFF_SRC_SEL   8'h60
`define AFCS_OFF_IN2_FUNC  8'h64
`define AFCS_OFF_SMOOTH    8'h68
`define AFCS_OFF_FREQ      8'h6c
`define AFCS_OFF_STATUS    8'h70
`define AFCS_RST_SPAN      14'h03e8
`define AFCS_RST_ZERO      14'h1388
`define AFCS_ZERO_MID      28'sh0001388
`define AFCS_RST_FREQ      16'h0000
`define AFCS_RST_SPT_U     8'sh00
`define AFCS_RST_SPT_B     8'sh9c
`define AFCS_RST_EPT       8'sh64
`define AFCS_RST_SEL_U     2'h1
`define AFCS_RST_SEL_B     2'h0
`define AFCS_RST_SRC_SEL   2'h0
`define AFCS_RST_IN2_FUNC  6'h10
`define AFCS_FUNC_SELECT   6'h10
`define AFCS_RST_SMOOTH    5'h08
`define AFCS_SMOOTH_MAX    5'h1e
`define AFCS_SPAN_SHIFT    12
`define AFCS_ADJ_HI        28'sh00003e8
`define AFCS_ADJ_LO_B      28'shffffc18
`define AFCS_LVL_FULL      12'h3e8
`define AFCS_LVL_BI_FULL   12'h7d0
`define AFCS_BI_OFS        12'h3e8
`define AFCS_PT_SCALE      13'sh00a
`define AFCS_FREQ_MAX      16'h9c40
`define AFCS_DIV_LAST      5'h1f
`define AFCS_MODE_ALONE    2'h0
`define AFCS_MODE_NOREV    2'h1
`define AFCS_MODE_OFF      2'h3
`endif

// file: core/afcs_pkg.sv
// Types shared by the analog frequency command scaler.
`default_nettype none
package afcs_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_DIV, ST_STORE, ST_OUT} seq_state_t;
  typedef logic [11:0] level_t;
  typedef logic [15:0] freq_t;
endpackage
`default_nettype wire

// file: core/analog_frequency_command_scaler.sv
// Sample FIFO and analog-to-frequency setpoint scaler.
// Contract
// - The 0 to 10 V reading maps its start point to the start frequency and its end point to the end frequency.
// - Below the voltage start point the output is the start frequency when the selection is 0 and 0 Hz when it is 1.
// - The voltage reading is corrected by its span and zero calibration values.
// - The 4 to 20 mA reading maps its start point to the start frequency and its end point to the end frequency.
// - Below the current start point the output is the start frequency when the selection is 0 and 0 Hz when it is 1.
// - The current reading is corrected by its span and zero calibration values.
// - The bipolar reading maps -10 V at its start point and +10 V at its end point.
// - The bipolar mode picks standalone, non-reversing auxiliary, auxiliary or disabled use.
// - With source selection 1 and the select terminal on, the command comes from the bipolar input unless the bipolar mode is disabled.
// - The bipolar reading is corrected by its span and zero calibration values.
// - All readings pass a low-pass filter whose factor runs 1 to 30 with 8 after reset.
// - The second input terminal holds the input-select function code 16 after reset.
`include "afcs_consts.svh"
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic [WIDTH-1:0]      rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  // Pointers wrap by overflow, so DEPTH must be a power of two.
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign wr_ready_out = (cnt_r != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign rd_valid_out = (cnt_r != '0);
  assign rd_data_out  = mem_r[rp_r];
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_r[wp_r] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_r + AW'(push);
      rp_r  <= rp_r + AW'(pop);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module analog_frequency_command_scaler
  import afcs_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire logic [11:0] voltage_sample_in,
  input  wire logic [11:0] current_loop_input_in,
  input  wire logic [11:0] bipolar_voltage_input_in,
  input  wire logic        sample_valid_in,
  output logic             sample_ready_out,
  input  wire logic        analog_source_select_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  output logic [31:0]      rd_data_out,
  output logic [15:0]      freq_cmd_out,
  output logic             reverse_out,
  output logic             freq_valid_out
);
  logic [13:0]       span_r [3];
  logic [13:0]       zero_r [3];
  freq_t             sfreq_r [3];
  freq_t             efreq_r [3];
  logic signed [7:0] spt_r [3];
  logic signed [7:0] ept_r [3];
  logic [1:0]        ssel_r [3];
  logic [1:0]        src_sel_r;
  logic [5:0]        in2_func_r;
  logic [4:0]        smooth_r;
  logic              at_meta_r;
  logic              at_sync_r;
  logic              at_act;
  logic [35:0]       fifo_word;
  logic              fifo_valid;
  logic              pop;
  level_t            x_cal [3];
  level_t            x_r [3];
  logic [16:0]       y_r [3];
  freq_t             res_r [2];
  seq_state_t        state_r;
  logic [2:0]        step_r;
  logic [4:0]        bit_r;
  logic [31:0]       num_r;
  logic [16:0]       rem_r;
  logic [15:0]       den_r;
  logic              use_cur_r;
  logic              bip_sw_r;
  freq_t             freq_cmd_r;
  logic              reverse_r;
  logic              freq_valid_r;
  logic [31:0]       rd_data_r;
  logic [31:0]       rd_mux;
  logic              ch_hit;
  logic [1:0]        mc;
  level_t            lv;
  level_t            ls;
  level_t            le;
  freq_t             fs;
  freq_t             fe;
  freq_t             dspan;
  logic              below;
  logic              above;
  logic [4:0]        k;
  logic [31:0]       fnum;
  logic [31:0]       dnum;
  logic [16:0]       rem_sh;
  logic              bneg;
  logic signed [17:0] tot;
  logic [17:0]       mag;
  freq_t             fin_freq;

  assign freq_cmd_out   = freq_cmd_r;
  assign reverse_out    = reverse_r;
  assign freq_valid_out = freq_valid_r;
  assign rd_data_out    = rd_data_r;
  assign pop            = fifo_valid && (state_r == ST_IDLE);

  sample_fifo #(.WIDTH(36), .DEPTH(8)) u_fifo (
    .clk_sys_in   (clk_sys_in),
    .reset_n_in   (reset_n_in),
    .wr_data_in   ({bipolar_voltage_input_in, current_loop_input_in, voltage_sample_in}),
    .wr_valid_in  (sample_valid_in),
    .wr_ready_out (sample_ready_out),
    .rd_data_out  (fifo_word),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (state_r == ST_IDLE)
  );

  // The terminal is a pin, so it is synchronised before anything looks at it.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      at_meta_r <= 1'b0;
      at_sync_r <= 1'b0;
    end else begin
      at_meta_r <= analog_source_select_in;
      at_sync_r <= at_meta_r;
    end
  end

  // The terminal only counts while it carries the input-select function.
  assign at_act = at_sync_r && (in2_func_r == `AFCS_FUNC_SELECT);

  assign ch_hit = !addr_in[7] && (addr_in[6:5] != 2'h3);

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < 3; i++) begin
        span_r[i]  <= `AFCS_RST_SPAN;
        zero_r[i]  <= `AFCS_RST_ZERO;
        sfreq_r[i] <= `AFCS_RST_FREQ;
        efreq_r[i] <= `AFCS_RST_FREQ;
        spt_r[i]   <= (i == 2) ? `AFCS_RST_SPT_B : `AFCS_RST_SPT_U;
        ept_r[i]   <= `AFCS_RST_EPT;
        ssel_r[i]  <= (i == 2) ? `AFCS_RST_SEL_B : `AFCS_RST_SEL_U;
      end
      src_sel_r  <= `AFCS_RST_SRC_SEL;
      in2_func_r <= `AFCS_RST_IN2_FUNC;
      smooth_r   <= `AFCS_RST_SMOOTH;
    end else if (wr_en_in && ch_hit) begin
      case (addr_in[4:2])
        `AFCS_FLD_SPAN:  span_r[addr_in[6:5]]  <= wr_data_in[13:0];
        `AFCS_FLD_ZERO:  zero_r[addr_in[6:5]]  <= wr_data_in[13:0];
        `AFCS_FLD_SFREQ: sfreq_r[addr_in[6:5]] <= wr_data_in[15:0];
        `AFCS_FLD_EFREQ: efreq_r[addr_in[6:5]] <= wr_data_in[15:0];
        `AFCS_FLD_SPT:   spt_r[addr_in[6:5]]   <= wr_data_in[7:0];
        `AFCS_FLD_EPT:   ept_r[addr_in[6:5]]   <= wr_data_in[7:0];
        `AFCS_FLD_SEL:   ssel_r[addr_in[6:5]]  <= wr_data_in[1:0];
        default: ;
      endcase
    end else if (wr_en_in) begin
      case (addr_in)
        `AFCS_OFF_SRC_SEL:  src_sel_r  <= wr_data_in[1:0];
        `AFCS_OFF_IN2_FUNC: in2_func_r <= wr_data_in[5:0];
        `AFCS_OFF_SMOOTH:   smooth_r   <= wr_data_in[4:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    if (ch_hit) begin
      case (addr_in[4:2])
        `AFCS_FLD_SPAN:  rd_mux = {18'h0, span_r[addr_in[6:5]]};
        `AFCS_FLD_ZERO:  rd_mux = {18'h0, zero_r[addr_in[6:5]]};
        `AFCS_FLD_SFREQ: rd_mux = {16'h0, sfreq_r[addr_in[6:5]]};
        `AFCS_FLD_EFREQ: rd_mux = {16'h0, efreq_r[addr_in[6:5]]};
        `AFCS_FLD_SPT:   rd_mux = {24'h0, spt_r[addr_in[6:5]]};
        `AFCS_FLD_EPT:   rd_mux = {24'h0, ept_r[addr_in[6:5]]};
        `AFCS_FLD_SEL:   rd_mux = {30'h0, ssel_r[addr_in[6:5]]};
        default:         rd_mux = 32'h0;
      endcase
    end else begin
      case (addr_in)
        `AFCS_OFF_SRC_SEL:  rd_mux = {30'h0, src_sel_r};
        `AFCS_OFF_IN2_FUNC: rd_mux = {26'h0, in2_func_r};
        `AFCS_OFF_SMOOTH:   rd_mux = {27'h0, smooth_r};
        `AFCS_OFF_FREQ:     rd_mux = {15'h0, reverse_r, freq_cmd_r};
        `AFCS_OFF_STATUS:   rd_mux = {28'h0, at_act, bip_sw_r, use_cur_r, state_r != ST_IDLE};
        default:            rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_r <= 32'h0;
    end else begin
      rd_data_r <= rd_en_in ? rd_mux : 32'h0;
    end
  end

  // Calibration clamps each reading to 0..1000 per mille, the bipolar one to 0..2000 around 1000.
  for (genvar g = 0; g < 3; g++) begin : g_cal
    logic signed [12:0] raw_s;
    logic signed [27:0] prod;
    logic signed [27:0] adj;
    assign raw_s = (g == 2) ? $signed({fifo_word[g*12+11], fifo_word[g*12+:12]})
                            : $signed({1'b0, fifo_word[g*12+:12]});
    assign prod  = 28'(raw_s) * $signed({14'h0, span_r[g]});
    assign adj   = (prod >>> `AFCS_SPAN_SHIFT) + $signed({14'h0, zero_r[g]}) - `AFCS_ZERO_MID;
    assign x_cal[g] = (adj > `AFCS_ADJ_HI) ? ((g == 2) ? `AFCS_LVL_BI_FULL : `AFCS_LVL_FULL) :
                      (adj < ((g == 2) ? `AFCS_ADJ_LO_B : 28'sh0)) ? 12'h000 :
                      adj[11:0] + ((g == 2) ? `AFCS_BI_OFS : 12'h000);
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        x_r[g] <= 12'h000;
      end else if (pop) begin
        x_r[g] <= x_cal[g];
      end
    end
  end

  function automatic level_t pt_lvl(input logic signed [7:0] p, input logic bi);
    logic signed [12:0] v;
    v = 13'(p) * `AFCS_PT_SCALE + (bi ? $signed({1'b0, `AFCS_BI_OFS}) : 13'sh0);
    return (v < 0) ? 12'h000 : v[11:0];
  endfunction

  always_comb begin
    mc     = (step_r == 3'h4) ? 2'h2 : {1'b0, use_cur_r};
    lv     = {1'b0, y_r[mc][16:6]};
    ls     = pt_lvl(spt_r[mc], mc == 2'h2);
    le     = pt_lvl(ept_r[mc], mc == 2'h2);
    fs     = sfreq_r[mc];
    fe     = efreq_r[mc];
    dspan  = (fe >= fs) ? fe - fs : fs - fe;
    below  = lv < ls;
    above  = lv >= le;
    k      = (smooth_r == 5'h0) ? 5'h1 : (smooth_r > `AFCS_SMOOTH_MAX) ? `AFCS_SMOOTH_MAX : smooth_r;
    fnum   = 32'(k - 5'h1) * 32'(y_r[step_r[1:0]]) + 32'({x_r[step_r[1:0]], 6'h0});
    dnum   = 32'(dspan) * 32'(lv - ls);
    rem_sh = {rem_r[15:0], num_r[31]};
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r   <= ST_IDLE;
      step_r    <= 3'h0;
      bit_r     <= 5'h0;
      num_r     <= 32'h0;
      rem_r     <= 17'h0;
      den_r     <= 16'h1;
      use_cur_r <= 1'b0;
      bip_sw_r  <= 1'b0;
      res_r[0]  <= 16'h0;
      res_r[1]  <= 16'h0;
      for (int i = 0; i < 3; i++) begin
        y_r[i] <= 17'h0;
      end
    end else begin
      case (state_r)
        ST_IDLE: begin
          step_r <= 3'h0;
          if (pop) begin
            use_cur_r <= (src_sel_r == 2'h0) && at_act;
            bip_sw_r  <= (src_sel_r == 2'h1) && at_act;
            state_r   <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          bit_r <= 5'h0;
          rem_r <= 17'h0;
          if (step_r < 3'h3) begin
            num_r   <= fnum;
            den_r   <= {11'h0, k};
            state_r <= ST_DIV;
          end else if (below) begin
            res_r[step_r[0] ? 1'b0 : 1'b1] <= (mc != 2'h2 && ssel_r[mc][0]) ? 16'h0 : fs;
            step_r  <= step_r + 3'h1;
            state_r <= (step_r == 3'h4) ? ST_OUT : ST_LOAD;
          end else if (above) begin
            res_r[step_r[0] ? 1'b0 : 1'b1] <= fe;
            step_r  <= step_r + 3'h1;
            state_r <= (step_r == 3'h4) ? ST_OUT : ST_LOAD;
          end else begin
            num_r   <= dnum;
            den_r   <= {4'h0, le - ls};
            state_r <= ST_DIV;
          end
        end
        ST_DIV: begin
          // One quotient bit per cycle keeps the area to a single subtractor.
          if (rem_sh >= {1'b0, den_r}) begin
            rem_r <= rem_sh - {1'b0, den_r};
            num_r <= {num_r[30:0], 1'b1};
          end else begin
            rem_r <= rem_sh;
            num_r <= {num_r[30:0], 1'b0};
          end
          bit_r <= bit_r + 5'h1;
          if (bit_r == `AFCS_DIV_LAST) begin
            state_r <= ST_STORE;
          end
        end
        ST_STORE: begin
          if (step_r < 3'h3) begin
            y_r[step_r[1:0]] <= num_r[16:0];
          end else begin
            res_r[step_r[0] ? 1'b0 : 1'b1] <= (fe >= fs) ? fs + num_r[15:0] : fs - num_r[15:0];
          end
          step_r  <= step_r + 3'h1;
          state_r <= (step_r == 3'h4) ? ST_OUT : ST_LOAD;
        end
        ST_OUT: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    bneg = {1'b0, y_r[2][16:6]} < `AFCS_BI_OFS;
    if (ssel_r[2] != `AFCS_MODE_OFF && (bip_sw_r || ssel_r[2] == `AFCS_MODE_ALONE)) begin
      tot = bneg ? -$signed({2'b0, res_r[1]}) : $signed({2'b0, res_r[1]});
    end else if (ssel_r[2] != `AFCS_MODE_OFF) begin
      tot = $signed({2'b0, res_r[0]}) + (bneg ? -$signed({2'b0, res_r[1]}) : $signed({2'b0, res_r[1]}));
      if (ssel_r[2] == `AFCS_MODE_NOREV && tot < 0) begin
        tot = 18'sh0;
      end
    end else begin
      tot = $signed({2'b0, res_r[0]});
    end
    mag      = (tot < 0) ? 18'(-tot) : 18'(tot);
    fin_freq = (mag > {2'b0, `AFCS_FREQ_MAX}) ? `AFCS_FREQ_MAX : mag[15:0];
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      freq_cmd_r   <= 16'h0;
      reverse_r    <= 1'b0;
      freq_valid_r <= 1'b0;
    end else begin
      freq_valid_r <= (state_r == ST_OUT);
      if (state_r == ST_OUT) begin
        freq_cmd_r <= fin_freq;
        reverse_r  <= tot < 0;
      end
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  property p_volt_cal;
    x_r[0] <= `AFCS_LVL_FULL;
  endproperty
  a_volt_cal: assert property (p_volt_cal) else $error("voltage level above full scale");
  property p_curr_cal;
    x_r[1] <= `AFCS_LVL_FULL;
  endproperty
  a_curr_cal: assert property (p_curr_cal) else $error("current level above full scale");
  property p_bi_cal;
    x_r[2] <= `AFCS_LVL_BI_FULL;
  endproperty
  a_bi_cal: assert property (p_bi_cal) else $error("bipolar level above full scale");
  property p_volt_below;
    state_r == ST_LOAD && step_r == 3'h3 && !use_cur_r && below && ssel_r[0] == 2'h1 |=> res_r[0] == 16'h0;
  endproperty
  a_volt_below: assert property (p_volt_below) else $error("voltage below start not zero");
  property p_curr_below;
    state_r == ST_LOAD && step_r == 3'h3 && use_cur_r && below && ssel_r[1] == 2'h0 |=> res_r[0] == sfreq_r[1];
  endproperty
  a_curr_below: assert property (p_curr_below) else $error("current below start not start freq");
  property p_above_end;
    state_r == ST_LOAD && step_r == 3'h3 && !below && above |=> res_r[0] == $past(fe);
  endproperty
  a_above_end: assert property (p_above_end) else $error("above end point not end freq");
  property p_latency;
    pop |-> ##[100:240] freq_valid_r;
  endproperty
  a_latency: assert property (p_latency) else $error("sample did not update command");
  property p_switch;
    state_r == ST_OUT && bip_sw_r && ssel_r[2] != `AFCS_MODE_OFF && !bneg && res_r[1] <= `AFCS_FREQ_MAX
      |=> freq_cmd_r == $past(res_r[1]) && !reverse_r;
  endproperty
  a_switch: assert property (p_switch) else $error("select terminal did not pick bipolar");
  property p_bi_off;
    state_r == ST_OUT && ssel_r[2] == `AFCS_MODE_OFF && res_r[0] <= `AFCS_FREQ_MAX
      |=> freq_cmd_r == $past(res_r[0]) && !reverse_r;
  endproperty
  a_bi_off: assert property (p_bi_off) else $error("disabled bipolar input changed command");
  property p_filter_den;
    state_r == ST_DIV && step_r < 3'h3 |-> den_r >= 16'h1 && den_r <= {11'h0, `AFCS_SMOOTH_MAX};
  endproperty
  a_filter_den: assert property (p_filter_den) else $error("filter factor out of range");
  property p_reset_vals;
    $rose(reset_n_in) |-> in2_func_r == `AFCS_RST_IN2_FUNC && smooth_r == `AFCS_RST_SMOOTH;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset defaults wrong");
  property p_fmax;
    freq_cmd_r <= `AFCS_FREQ_MAX;
  endproperty
  a_fmax: assert property (p_fmax) else $error("command above 400 Hz");
endmodule
`default_nettype wire

// file: tb/afcs_far_side.sv
// Far-side model: analog sample source and frequency command consumer.
`default_nettype none
module afcs_far_side (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire logic        sample_ready_in,
  input  wire logic [15:0] freq_cmd_in,
  input  wire logic        reverse_in,
  input  wire logic        freq_valid_in,
  output logic      [11:0] voltage_code_out,
  output logic      [11:0] current_code_out,
  output logic      [11:0] bipolar_code_out,
  output logic             sample_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [16:0] last_cmd_r;
  int          updates;
  initial begin
    voltage_code_out = 12'h000;
    current_code_out = 12'h000;
    bipolar_code_out = 12'h000;
    sample_valid_out = 1'b0;
  end
  // Holds the whole sample until it is taken, so a full buffer only stretches the wait.
  task automatic push(input logic [11:0] v, input logic [11:0] c, input logic [11:0] b);
    voltage_code_out <= v;
    current_code_out <= c;
    bipolar_code_out <= b;
    sample_valid_out <= 1'b1;
    do @(posedge clk_sys_in); while (sample_ready_in !== 1'b1);
  endtask
  // Released codes are inverted so a stale sample never looks valid by chance.
  task automatic idle();
    sample_valid_out <= 1'b0;
    voltage_code_out <= ~voltage_code_out;
    current_code_out <= ~current_code_out;
    bipolar_code_out <= ~bipolar_code_out;
  endtask
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      last_cmd_r <= 17'h0;
      updates    <= 0;
    end else if (freq_valid_in) begin
      last_cmd_r <= {reverse_in, freq_cmd_in};
      updates    <= updates + 1;
    end
  end
endmodule
`default_nettype wire

// file: tb/test_analog_frequency_command_scaler.sv
// Self-checking bench for the analog frequency command scaler.
`default_nettype none
module test_analog_frequency_command_scaler;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        analog_source_select_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wr_data_in = 32'h0;
  logic        wr_en_in = 1'b0;
  logic        rd_en_in = 1'b0;
  logic [11:0] voltage_sample_in, current_loop_input_in, bipolar_voltage_input_in;
  logic        sample_valid_in, sample_ready_out, reverse_out, freq_valid_out;
  logic [31:0] rd_data_out;
  logic [15:0] freq_cmd_out;
  int          errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  analog_frequency_command_scaler i_dut (.clk_sys_in, .reset_n_in, .voltage_sample_in, .current_loop_input_in,
    .bipolar_voltage_input_in, .sample_valid_in, .sample_ready_out, .analog_source_select_in, .addr_in,
    .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out, .freq_cmd_out, .reverse_out, .freq_valid_out);
  afcs_far_side i_far (.clk_sys_in, .reset_n_in, .sample_ready_in(sample_ready_out), .freq_cmd_in(freq_cmd_out),
    .reverse_in(reverse_out), .freq_valid_in(freq_valid_out), .voltage_code_out(voltage_sample_in),
    .current_code_out(current_loop_input_in), .bipolar_code_out(bipolar_voltage_input_in),
    .sample_valid_out(sample_valid_in));
  always #10 clk_sys_in = ~clk_sys_in;
  task automatic wrap_up();
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_in    <= a;
    wr_data_in <= d;
    wr_en_in   <= 1'b1;
    @(posedge clk_sys_in);
    wr_en_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    addr_in  <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_en_in <= 1'b0;
    #1 chk(rd_data_out & mask, exp);
    @(posedge clk_sys_in);
  endtask
  task automatic cfg(input logic [7:0] b, input logic [15:0] sf, ef, input logic [7:0] sp, ep, input logic [1:0] s);
    wr(b + 8'h08, {16'h0, sf});
    wr(b + 8'h0c, {16'h0, ef});
    wr(b + 8'h10, {24'h0, sp});
    wr(b + 8'h14, {24'h0, ep});
    wr(b + 8'h18, {30'h0, s});
  endtask
  task automatic send(input logic [11:0] v, c, b, output logic [16:0] got);
    int n;
    n = i_far.updates;
    i_far.push(v, c, b);
    i_far.idle();
    for (int k = 0; k < 400 && i_far.updates == n; k++) @(posedge clk_sys_in);
    if (i_far.updates == n) begin
      errors++;
      $display("BAD %0t no command update", $time);
    end
    #1 got = {reverse_out, freq_cmd_out};
    @(posedge clk_sys_in);
  endtask
  task automatic smp(input logic [11:0] v, c, b, input logic [16:0] exp);
    logic [16:0] got;
    send(v, c, b, got);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  task automatic t_reset();
    rd(8'h68, 32'h1f, 32'h8);
    rd(8'h64, 32'h3f, 32'h10);
    rd(8'h18, 32'h3, 32'h1);
    rd(8'h38, 32'h3, 32'h1);
    rd(8'h58, 32'h3, 32'h0);
    rd(8'h50, 32'hff, 32'h9c);
    rd(8'h54, 32'hff, 32'h64);
    rd(8'h14, 32'hff, 32'h64);
    rd(8'h7c, 32'hffffffff, 32'h0);
  endtask
  task automatic t_filter();
    logic [16:0] g1, g2;
    wr(8'h58, 32'h3);
    cfg(8'h00, 16'd0, 16'd40000, 8'd0, 8'd100, 2'h1);
    send(12'hfff, 12'h0, 12'h0, g1);
    send(12'hfff, 12'h0, 12'h0, g2);
    chk({31'h0, g1[15:0] > 16'h0 && g1[15:0] < g2[15:0] && g2[15:0] < 16'd40000}, 32'h1);
    wr(8'h68, 32'h1);
  endtask
  task automatic t_voltage();
    cfg(8'h00, 16'd1000, 16'd30000, 8'd10, 8'd50, 2'h1);
    smp(12'hfff, 12'h0, 12'h0, 17'd30000);
    smp(12'h000, 12'h0, 12'h0, 17'd0);
    smp(12'd1229, 12'h0, 12'h0, 17'd15500);
    wr(8'h04, 32'd5100);
    smp(12'd820, 12'h0, 12'h0, 17'd15500);
    wr(8'h04, 32'd5000);
    wr(8'h00, 32'd2000);
    smp(12'd615, 12'h0, 12'h0, 17'd15500);
    wr(8'h00, 32'd1000);
    wr(8'h18, 32'h0);
    smp(12'h000, 12'h0, 12'h0, 17'd1000);
    rd(8'h6c, 32'h1ffff, 32'd1000);
    wr(8'h18, 32'h1);
  endtask
  task automatic t_current();
    analog_source_select_in <= 1'b1;
    cfg(8'h20, 16'd2000, 16'd20000, 8'd10, 8'd100, 2'h1);
    smp(12'hfff, 12'd2048, 12'h0, 17'd10000);
    rd(8'h70, 32'h2, 32'h2);
    rd(8'h70, 32'h8, 32'h8);
    wr(8'h64, 32'h0);
    rd(8'h70, 32'h8, 32'h0);
    wr(8'h64, 32'h10);
    smp(12'hfff, 12'h0, 12'h0, 17'd0);
    wr(8'h38, 32'h0);
    smp(12'hfff, 12'h0, 12'h0, 17'd2000);
    wr(8'h20, 32'd2000);
    smp(12'hfff, 12'd1024, 12'h0, 17'd10000);
    wr(8'h20, 32'd1000);
    analog_source_select_in <= 1'b0;
  endtask
  task automatic t_bipolar();
    cfg(8'h40, 16'd5000, 16'd20000, 8'hce, 8'd50, 2'h0);
    smp(12'hfff, 12'h0, 12'h7ff, {1'b0, 16'd19985});
    smp(12'hfff, 12'h0, 12'h800, {1'b1, 16'd5000});
    wr(8'h40, 32'd2000);
    smp(12'h000, 12'h0, 12'h400, {1'b0, 16'd20000});
    wr(8'h40, 32'd1000);
    wr(8'h58, 32'h2);
    smp(12'h000, 12'h0, 12'h800, {1'b1, 16'd5000});
    wr(8'h58, 32'h1);
    smp(12'h000, 12'h0, 12'h800, 17'd0);
    wr(8'h60, 32'h1);
    analog_source_select_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    smp(12'hfff, 12'h0, 12'h7ff, 17'd19985);
    wr(8'h58, 32'h3);
    smp(12'hfff, 12'h0, 12'h7ff, 17'd30000);
    analog_source_select_in <= 1'b0;
    wr(8'h60, 32'h0);
  endtask
  task automatic t_fifo();
    int n;
    n = i_far.updates;
    for (int k = 0; k < 9; k++) i_far.push(12'hfff, 12'h0, 12'h0);
    i_far.idle();
    #1 chk({31'h0, sample_ready_out}, 32'h0);
    for (int k = 0; k < 4000 && i_far.updates != n + 9; k++) @(posedge clk_sys_in);
    #1 chk(32'(i_far.updates - n), 32'd9);
    chk({15'h0, i_far.last_cmd_r}, 32'd30000);
    chk({31'h0, sample_ready_out}, 32'h1);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    t_reset();
    t_filter();
    t_voltage();
    t_current();
    t_bipolar();
    t_fifo();
    wrap_up();
  end
endmodule
`default_nettype wire
